// [hw/cgo_top.sv]
// Clock generator interrupt flags, enables and clock output, APB slave.
// Assumes oscillator clocks arrive as asynchronous levels sampled at 100 MHz.
`timescale 1ns/1ps
`include "cgo_consts.svh"
module cgo_top
  import cgo_pkg::*;
#(
  parameter int HS_WAIT_MAX = 65536
) (
  // System
  input wire logic sys_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator clocks and events, asynchronous
  input wire logic internal_osc_clock,
  input wire logic lowspeed_osc_clock,
  input wire logic highspeed_osc_clock,
  input wire logic lowspeed_stop_evt,
  input wire logic trim_done_evt,
  input wire logic lowspeed_stable_evt,
  input wire logic internal_stable_evt,
  input wire logic highspeed_start,
  // System clock gating state
  input wire logic standby,
  // Outputs
  output logic clk_out_pin,
  output logic clk_out_oe,
  output logic clk_irq
);
  initial begin
    if (HS_WAIT_MAX < 65536) $error("cgo_top: HS_WAIT_MAX too small");
  end
  // ==========================================
  // Input synchronisers, two flops per line
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] async_in, sync1_reg, sync2_reg, prev_reg;
  assign async_in = {highspeed_start, internal_stable_evt, lowspeed_stable_evt, trim_done_evt,
                     lowspeed_stop_evt, highspeed_osc_clock, lowspeed_osc_clock, internal_osc_clock};
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  logic [NSYNC-1:0] rise, lvl_chg;
  assign rise = sync2_reg & ~prev_reg;
  // Either edge; ratio 1 needs both so the pin copies the source clock
  assign lvl_chg = sync2_reg ^ prev_reg;
  // ==========================================
  // APB decode
  logic wr_acc, rd_acc;
  logic addr_ok;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign addr_ok = (paddr == `CGO_FLAGS_OFS) || (paddr == `CGO_ENABLES_OFS) ||
                   (paddr == `CGO_OUTCTL_OFS) || (paddr == `CGO_HSWAIT_OFS);
  assign pready = 1'b1; // Zero wait states
  assign pslverr = psel && penable && !addr_ok;
  // ==========================================
  // High-speed stabilization wait
  logic [2:0] highspeed_wait_select_reg;
  always_ff @(posedge sys_clk) begin
    if (!rstn) highspeed_wait_select_reg <= `CGO_HSWAIT_RST;
    else if (wr_acc && paddr == `CGO_HSWAIT_OFS) highspeed_wait_select_reg <= pwdata[2:0];
  end
  // Wait counts in cycles: 4 times 4 to the power of the select
  logic [16:0] hs_limit;
  assign hs_limit = 17'h00004 << {highspeed_wait_select_reg, 1'b0};
  logic [16:0] hs_cnt_reg;
  logic hs_busy_reg, hs_done;
  assign hs_done = hs_busy_reg && (hs_cnt_reg == hs_limit - 17'h00001);
  // Start restarts the wait; completion after exactly hs_limit cycles
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hs_busy_reg <= 1'b0;
      hs_cnt_reg <= '0;
    end else if (rise[7]) begin
      hs_busy_reg <= 1'b1;
      hs_cnt_reg <= '0;
    end else if (hs_done) begin
      hs_busy_reg <= 1'b0;
    end else if (hs_busy_reg) begin
      hs_cnt_reg <= hs_cnt_reg + 17'h00001;
    end
  end
  // ==========================================
  // Interrupt flags and enables
  cgo_events_type evt;
  assign evt = '{lowspeed_stop: rise[3], trim_done: rise[4], highspeed_stable: hs_done,
                 lowspeed_stable: rise[5], internal_stable: rise[6]};
  logic [5:0] set_vec;
  assign set_vec = {evt.lowspeed_stop, evt.trim_done, 1'b0, evt.highspeed_stable,
                    evt.lowspeed_stable, evt.internal_stable};
  logic [5:0] flags_reg, enables_reg, clr_vec;
  assign clr_vec = (wr_acc && paddr == `CGO_FLAGS_OFS) ? (pwdata[5:0] & `CGO_FLAG_MASK) : 6'h00;
  // Set beats clear so no event is lost; reset leaves internal stable at 0
  always_ff @(posedge sys_clk) begin
    if (!rstn) flags_reg <= `CGO_FLAGS_RST;
    else flags_reg <= (flags_reg & ~clr_vec) | set_vec;
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) enables_reg <= `CGO_ENABLES_RST;
    else if (wr_acc && paddr == `CGO_ENABLES_OFS) enables_reg <= pwdata[5:0] & `CGO_FLAG_MASK;
  end
  // Level request from any enabled flag
  assign clk_irq = |(flags_reg & enables_reg);
  // ==========================================
  // Clock output control
  cgo_outctl_type outctl_reg;
  always_ff @(posedge sys_clk) begin
    if (!rstn) outctl_reg <= `CGO_OUTCTL_RST;
    else if (wr_acc && paddr == `CGO_OUTCTL_OFS) outctl_reg <= {pwdata[6:2], 1'b0, pwdata[0]};
  end
  // Source tick: rising edge of the chosen clock, or both edges at ratio 1
  // System tick every cycle unless standby; ratio 1 there is limited to half sys_clk
  logic src_tick;
  logic ratio_one;
  assign ratio_one = (outctl_reg.clk_out_divide == 3'h0);
  always_comb begin
    unique case (outctl_reg.clk_out_source)
      CGO_SRC_INTERNAL: src_tick = ratio_one ? lvl_chg[0] : rise[0];
      CGO_SRC_LOWSPEED: src_tick = ratio_one ? lvl_chg[1] : rise[1];
      CGO_SRC_HIGHSPEED: src_tick = ratio_one ? lvl_chg[2] : rise[2];
      CGO_SRC_SYSTEM: src_tick = !standby;
    endcase
  end
  // Division exponent per source; system source is held at ratio 1
  logic [3:0] exponent;
  always_comb begin
    exponent = {1'b0, outctl_reg.clk_out_divide};
    if (outctl_reg.clk_out_source == CGO_SRC_LOWSPEED) begin
      unique case (outctl_reg.clk_out_divide)
        3'h4: exponent = 4'h8;
        3'h5: exponent = 4'hA;
        3'h6: exponent = 4'hC;
        3'h7: exponent = 4'hF;
        default: exponent = {1'b0, outctl_reg.clk_out_divide};
      endcase
    end else if (outctl_reg.clk_out_source == CGO_SRC_SYSTEM) begin
      exponent = 4'h0;
    end
  end
  logic div_level;
  cgo_divider #(.WIDTH(15)) u_div (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .tick(src_tick),
    .exponent(exponent),
    .div_out(div_level)
  );
  // Enable gates asynchronously to the divided phase; glitch accepted
  always_ff @(posedge sys_clk) begin
    if (!rstn) clk_out_pin <= 1'b0;
    else clk_out_pin <= outctl_reg.clk_out_enable & div_level;
  end
  assign clk_out_oe = outctl_reg.clk_out_enable;
  // ==========================================
  // Read data
  always_ff @(posedge sys_clk) begin
    if (!rstn) prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CGO_FLAGS_OFS: prdata <= {26'h0, flags_reg};
        `CGO_ENABLES_OFS: prdata <= {26'h0, enables_reg};
        `CGO_OUTCTL_OFS: prdata <= {25'h0, outctl_reg};
        `CGO_HSWAIT_OFS: prdata <= {29'h0, highspeed_wait_select_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
  // ==========================================
  // Checks
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_irq == |(flags_reg & enables_reg)) else $error("irq mismatch");
  a_w1c_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_acc && paddr == `CGO_FLAGS_OFS && pwdata[5] && !evt.lowspeed_stop) |=> !flags_reg[5])
    else $error("flag not cleared");
  a_w0_keep: assert property (@(posedge sys_clk) disable iff (!rstn)
    (flags_reg[4] && !(wr_acc && paddr == `CGO_FLAGS_OFS && pwdata[4])) |=> flags_reg[4])
    else $error("flag lost");
  a_stop_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    evt.lowspeed_stop |=> flags_reg[5]) else $error("stop flag not set");
  a_trim_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    evt.trim_done |=> flags_reg[4]) else $error("trim flag not set");
  a_hs_stable: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rise[7] && highspeed_wait_select_reg == 3'h0 && !hs_busy_reg) ##1
    (!rise[7] && highspeed_wait_select_reg == 3'h0) [*4] |=> flags_reg[2])
    else $error("high-speed wait wrong");
  a_reset_clean: assert property (@(posedge sys_clk) $rose(rstn) |-> !flags_reg[0])
    else $error("internal flag set after reset");
  a_en_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_acc && paddr == `CGO_ENABLES_OFS) |=> enables_reg == $past(pwdata[5:0] & `CGO_FLAG_MASK))
    else $error("enable write lost");
  a_out_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    !outctl_reg.clk_out_enable |=> !clk_out_pin) else $error("output while disabled");
  a_sys_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
    (outctl_reg.clk_out_source == CGO_SRC_SYSTEM && standby) |-> !src_tick)
    else $error("system tick in standby");
  c_irq: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(clk_irq));
  c_hs_done: cover property (@(posedge sys_clk) disable iff (!rstn) hs_done);
  c_pin_toggle: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(clk_out_pin));
  c_set_clear: cover property (@(posedge sys_clk) disable iff (!rstn) |(set_vec & clr_vec));
  c_sys_standby: cover property (@(posedge sys_clk) disable iff (!rstn)
    outctl_reg.clk_out_source == CGO_SRC_SYSTEM && standby);
  // ==========================================
  // Stabilization flags, ratio selection, system tick, interrupt drop and pin off
  a_ls_stab_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    evt.lowspeed_stable |=> flags_reg[1]) else $error("low-speed stable flag not set");
  a_in_stab_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    evt.internal_stable |=> flags_reg[0]) else $error("internal stable flag not set");
  a_hs_done_busy: assert property (@(posedge sys_clk) disable iff (!rstn)
    hs_done |=> !hs_busy_reg) else $error("high-speed wait kept running");
  a_irq_drop: assert property (@(posedge sys_clk) disable iff (!rstn)
    ((flags_reg & enables_reg) == 6'h00) |-> !clk_irq) else $error("irq without cause");
  a_fast_ratio: assert property (@(posedge sys_clk) disable iff (!rstn)
    (outctl_reg.clk_out_source == CGO_SRC_INTERNAL || outctl_reg.clk_out_source == CGO_SRC_HIGHSPEED)
    |-> exponent == {1'b0, outctl_reg.clk_out_divide}) else $error("fast ratio wrong");
  a_ls_long_div: assert property (@(posedge sys_clk) disable iff (!rstn)
    (outctl_reg.clk_out_source == CGO_SRC_LOWSPEED && outctl_reg.clk_out_divide == 3'h7)
    |-> exponent == 4'hF) else $error("low-speed long ratio wrong");
  a_sys_ratio: assert property (@(posedge sys_clk) disable iff (!rstn)
    outctl_reg.clk_out_source == CGO_SRC_SYSTEM |-> exponent == 4'h0)
    else $error("system ratio not one");
  a_sys_run: assert property (@(posedge sys_clk) disable iff (!rstn)
    (outctl_reg.clk_out_source == CGO_SRC_SYSTEM && !standby) |-> src_tick)
    else $error("system tick missing");
  a_pin_oe_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    !clk_out_oe |=> !clk_out_pin) else $error("pin high while not driven");
endmodule : cgo_top

// [hw/cgo_consts.svh]
// Constants for the clock generator interrupt and clock output block.
// Assumes inclusion by bare name from any design file that needs it.
// Function
// - Set stop flag bit5 on low-speed stop, trim flag bit4 on trim done.
// - Writing one clears a flag bit; writing zero leaves it.
// - Stable flags bits 2,1,0 for high-speed, low-speed, internal oscillators.
// - Internal stable flag reads zero after reset release.
// - Enable bits 5 and 4 gate stop and trim interrupts.
// - Enable bits 2,1,0 gate the three stabilization interrupts.
// - Source field picks internal, low-speed, high-speed or system clock.
// - Internal and high-speed sources divide by 1 to 128.
// - Low-speed divides 1,2,4,8,256,1024,4096,32768; system only by 1.
// - System clock source output stops during sleep and halt.
// - Output enable bit drives divided clock to pin; zero disables it.
// - Enable not synchronised to output; a glitch is tolerated.
// - High-speed wait select gives 4 to 65536 cycles.
`ifndef CGO_CONSTS_SVH
`define CGO_CONSTS_SVH
// ==========================================
// Register byte offsets
`define CGO_FLAGS_OFS 12'h000
`define CGO_ENABLES_OFS 12'h004
`define CGO_OUTCTL_OFS 12'h008
`define CGO_HSWAIT_OFS 12'h00C
// ==========================================
// Field positions
`define CGO_BIT_LS_STOP 5
`define CGO_BIT_TRIM 4
`define CGO_BIT_HS_STAB 2
`define CGO_BIT_LS_STAB 1
`define CGO_BIT_IN_STAB 0
`define CGO_FLAG_MASK 6'h37
`define CGO_OUT_EN_BIT 0
`define CGO_OUT_SRC_LSB 2
`define CGO_OUT_DIV_LSB 4
// ==========================================
// Reset values
`define CGO_FLAGS_RST 6'h00
`define CGO_ENABLES_RST 6'h00
`define CGO_OUTCTL_RST 7'h00
`define CGO_HSWAIT_RST 3'h0
`endif

// [hw/cgo_pkg.sv]
// Types for the clock generator interrupt and clock output block.
// Assumes no other package.
package cgo_pkg;
  // Clock output source selection
  typedef enum logic [1:0] {
    CGO_SRC_INTERNAL = 2'h0,
    CGO_SRC_LOWSPEED = 2'h1,
    CGO_SRC_HIGHSPEED = 2'h2,
    CGO_SRC_SYSTEM = 2'h3
  } cgo_src_type;
  // Clock output control fields
  typedef struct packed {
    logic [2:0] clk_out_divide;
    cgo_src_type clk_out_source;
    logic reserved;
    logic clk_out_enable;
  } cgo_outctl_type;
  // Oscillator event pulses
  typedef struct packed {
    logic lowspeed_stop;
    logic trim_done;
    logic highspeed_stable;
    logic lowspeed_stable;
    logic internal_stable;
  } cgo_events_type;
endpackage : cgo_pkg

// [hw/cgo_divider.sv]
// Power-of-two clock divider driven by one-cycle source ticks.
// Assumes ticks already synchronised to sys_clk.
`timescale 1ns/1ps
module cgo_divider
  import cgo_pkg::*;
#(
  parameter int WIDTH = 15
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Source tick and ratio exponent
  input wire logic tick,
  input wire logic [3:0] exponent,
  // Divided level
  output logic div_out
);
  initial begin
    if (WIDTH < 15) $error("cgo_divider: WIDTH must be at least 15");
  end
  logic [WIDTH-1:0] cnt_reg;
  // Free counter; tapping bit exponent-1 halves per step
  always_ff @(posedge sys_clk) begin
    if (!rstn) cnt_reg <= '0;
    else if (tick) cnt_reg <= cnt_reg + 1'b1;
  end
  // Ratio 1 is the raw tick toggle, stretched to a level
  logic raw_reg;
  always_ff @(posedge sys_clk) begin
    if (!rstn) raw_reg <= 1'b0;
    else if (tick) raw_reg <= ~raw_reg;
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) div_out <= 1'b0;
    else if (exponent == 4'h0) div_out <= raw_reg;
    else div_out <= cnt_reg[exponent - 4'h1];
  end
endmodule : cgo_divider

// [verif/cgo_clk_out_pin_rx.sv]
// Model of the external device that receives the divided clock.
// Assumes the pin is sampled on sys_clk and is only valid while oe is high.
`timescale 1ns/1ps
module cgo_clk_out_pin_rx (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Received clock
  input wire logic pin,
  input wire logic oe,
  // Measurements
  output logic [31:0] period,
  output logic [31:0] edges
);
  logic last_reg;
  logic [31:0] cnt_reg;
  // ==========================================
  // Rising edges counted only while driven; an undriven line means nothing
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      last_reg <= 1'b0;
      cnt_reg <= 32'h0;
      period <= 32'h0;
      edges <= 32'h0;
    end else begin
      last_reg <= pin & oe;
      cnt_reg <= cnt_reg + 32'h1;
      if ((pin & oe) && !last_reg) begin
        period <= cnt_reg + 32'h1; // Cycles since previous rise
        cnt_reg <= 32'h0;
        edges <= edges + 32'h1;
      end
    end
  end
endmodule : cgo_clk_out_pin_rx

// [verif/test_cgo_top.sv]
// Self-checking bench for the clock interrupt and clock output block.
// Assumes 100 MHz sys_clk and slow oscillator clocks made here.
`timescale 1ns/1ps
`include "cgo_consts.svh"
module test_cgo_top
  import cgo_pkg::*;
;
  typedef struct packed {logic [6:0] ctl; logic [31:0] per;} cgo_row_type;
  logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, per, edg, e0;
  logic pready, pslverr, clk_out_pin, clk_out_oe, clk_irq, serr;
  logic iosc = 0, losc = 0, hosc = 0, standby = 0;
  logic [4:0] evt = 5'h00; // Bit 4 starts the high-speed wait
  int n_fail = 0, checked = 0;
  // Control word and expected pin period in sys_clk cycles
  cgo_row_type rows [6] = '{'{7'h01, 32'd8}, '{7'h31, 32'd64}, '{7'h35, 32'd128},
    '{7'h45, 32'd4096}, '{7'h19, 32'd12}, '{7'h79, 32'd768}};
  // ==========================================
  // Clocks; oscillator phases kept off the sys_clk edges
  initial forever #5 sys_clk = ~sys_clk;
  initial begin #3; forever #40 iosc = ~iosc; end
  initial begin #7; forever #80 losc = ~losc; end
  initial begin #2; forever #30 hosc = ~hosc; end
  cgo_top uut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_osc_clock(iosc), .lowspeed_osc_clock(losc), .highspeed_osc_clock(hosc),
    .lowspeed_stop_evt(evt[3]), .trim_done_evt(evt[2]), .lowspeed_stable_evt(evt[1]),
    .internal_stable_evt(evt[0]), .highspeed_start(evt[4]), .standby(standby),
    .clk_out_pin(clk_out_pin), .clk_out_oe(clk_out_oe), .clk_irq(clk_irq));
  cgo_clk_out_pin_rx rx (.sys_clk(sys_clk), .rstn(rstn), .pin(clk_out_pin), .oe(clk_out_oe),
    .period(per), .edges(edg));
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // Async event held three cycles so the synchroniser cannot miss it
  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    cyc(3);
    evt[i] <= 1'b0;
  endtask : pulse
  // Bounded wait for k more received edges
  task automatic wait_edges(input int k);
    e0 = edg;
    for (int n = 0; n < 20000 && edg < e0 + k; n++) @(posedge sys_clk);
  endtask : wait_edges
  task automatic final_report;
    if (n_fail == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // ==========================================
  // Watchdog, well beyond the longest expected run
  initial begin
    #900000;
    n_fail++;
    final_report;
  end
  // ==========================================
  // Main sequence
  initial begin
    cyc(10);
    rstn <= 1'b1;
    rd(`CGO_FLAGS_OFS, 32'h0, "flags");
    rd(`CGO_ENABLES_OFS, 32'h0, "enables");
    rd(`CGO_OUTCTL_OFS, 32'h0, "outctl");
    chk("oe", 32'h0, {31'h0, clk_out_oe});
    apb(1'b1, `CGO_ENABLES_OFS, 32'hFFFF);
    rd(`CGO_ENABLES_OFS, 32'h37, "enables mask");
    apb(1'b1, `CGO_OUTCTL_OFS, 32'hFFFE);
    rd(`CGO_OUTCTL_OFS, 32'h7C, "outctl mask");
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("slverr", 32'h1, {31'h0, serr});
    apb(1'b1, `CGO_ENABLES_OFS, 32'h0);
    apb(1'b1, `CGO_OUTCTL_OFS, 32'h0);
    apb(1'b1, `CGO_HSWAIT_OFS, 32'h0);
    for (int i = 0; i < 5; i++) pulse(i);
    cyc(30);
    rd(`CGO_FLAGS_OFS, 32'h37, "flags set");
    chk("irq masked", 32'h0, {31'h0, clk_irq});
    apb(1'b1, `CGO_FLAGS_OFS, 32'h0);
    rd(`CGO_FLAGS_OFS, 32'h37, "flags w0");
    apb(1'b1, `CGO_ENABLES_OFS, 32'h20);
    cyc(1);
    chk("irq stop", 32'h1, {31'h0, clk_irq});
    apb(1'b1, `CGO_FLAGS_OFS, 32'h20);
    rd(`CGO_FLAGS_OFS, 32'h17, "flags w1");
    chk("irq off", 32'h0, {31'h0, clk_irq});
    apb(1'b1, `CGO_ENABLES_OFS, 32'h17);
    cyc(1);
    chk("irq rest", 32'h1, {31'h0, clk_irq});
    apb(1'b1, `CGO_FLAGS_OFS, 32'h37);
    rd(`CGO_FLAGS_OFS, 32'h0, "flags clr");
    chk("irq clr", 32'h0, {31'h0, clk_irq});
    // Wait select 1 is 16 cycles: not yet set early, set well after
    apb(1'b1, `CGO_HSWAIT_OFS, 32'h1);
    pulse(4);
    rd(`CGO_FLAGS_OFS, 32'h0, "hs early");
    cyc(30);
    rd(`CGO_FLAGS_OFS, 32'h4, "hs done");
    // Internal, low-speed and high-speed sources at several ratios, including the low-speed 256 ratio
    foreach (rows[i]) begin
      apb(1'b1, `CGO_OUTCTL_OFS, {25'h0, rows[i].ctl});
      wait_edges(3);
      chk("period", rows[i].per, per);
    end
    apb(1'b1, `CGO_OUTCTL_OFS, 32'h78);
    cyc(4);
    chk("oe off", 32'h0, {31'h0, clk_out_oe});
    chk("pin off", 32'h0, {31'h0, clk_out_pin});
    // System source must freeze in standby and resume after
    standby <= 1'b1;
    apb(1'b1, `CGO_OUTCTL_OFS, 32'h0D);
    cyc(4);
    e0 = edg;
    cyc(50);
    chk("standby", e0, edg);
    standby <= 1'b0;
    wait_edges(2);
    chk("sys run", 32'h1, 32'(edg >= e0 + 2));
    final_report;
  end
endmodule : test_cgo_top
